// ===== dv/dclr_far_end.sv
// Purpose: receiving station on one channel, logs every char
// Assumes: valid/ready byte stream from the relay
// Notes: stall mode accepts one cycle in four
`timescale 1ns/100ps
module dclr_far_end (
    input wire mclk_i,
    input wire resetn_i,
    input wire stall_i,
    input wire tx_valid_i,
    output reg tx_ready_o,
    input wire [7:0] tx_data_i
);
    reg [7:0] got_q[$];
    reg [1:0] cnt_reg;
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            cnt_reg <= 2'h0;
            tx_ready_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 2'h1;
            tx_ready_o <= !stall_i || cnt_reg == 2'h3;
            if (tx_valid_i && tx_ready_o)
                got_q.push_back(tx_data_i);
        end
    end
endmodule

// ===== dv/dclr_link_relay_properties.sv
// Purpose: concurrent checks on the link relay ports
// Assumes: registered mode and exec outputs
// Notes: shadows CTRL and STATION from APB writes
`timescale 1ns/100ps
`include "dclr_consts.vh"
module dclr_link_props #(
    parameter HDR_DEPTH = 16
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pslverr_o,
    input wire ch1_rx_valid_i,
    input wire ch1_rx_ready_o,
    input wire [7:0] ch1_rx_data_i,
    input wire ch1_tx_valid_o,
    input wire [7:0] ch1_tx_data_o,
    input wire ch2_rx_valid_i,
    input wire ch2_rx_ready_o,
    input wire [7:0] ch2_rx_data_i,
    input wire ch2_tx_valid_o,
    input wire ch2_tx_ready_i,
    input wire [7:0] ch2_tx_data_o,
    input wire cmd_station_valid_i,
    input wire [4:0] cmd_station_i,
    input wire cmd_exec_o,
    input wire [1:0] ch1_mode_o,
    input wire [1:0] ch2_mode_o,
    input wire loopback_o,
    input wire memtest_o
);
    reg [8:0] ctrl_h;
    reg [4:0] stn_h;
    wire wr_acc = psel_i && penable_i && pwrite_i;
    wire linked = ctrl_h[3:0] == `DCLR_PROTO_LINKED;
    wire np_link = linked && ctrl_h[7:4] == `DCLR_PROTO_NONPROC;
    wire no_lb = ctrl_h[3:0] != `DCLR_PROTO_LOOPBACK && ctrl_h[7:4] != `DCLR_PROTO_LOOPBACK;
    wire bad_addr = paddr_i >= 12'h080 || (paddr_i > 12'h008 && paddr_i < 12'h040);
    wire [3:0] eff1 = linked ? ctrl_h[7:4] : ctrl_h[3:0];
    function [1:0] mode_of(input [3:0] c);
        mode_of = c == 4'h0 ? 2'h0 : c < 4'h5 ? 2'h1 : c == 4'h5 ? 2'h2 : 2'h3;
    endfunction
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            ctrl_h <= 9'h100;
            stn_h <= 5'h00;
        end else if (wr_acc && paddr_i == `DCLR_OFF_CTRL) begin
            ctrl_h <= pwdata_i[8:0];
        end else if (wr_acc && paddr_i == `DCLR_OFF_STATION) begin
            stn_h <= pwdata_i[4:0];
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    exec_on_match_a: assert property (cmd_exec_o |-> $past(cmd_station_valid_i && cmd_station_i == stn_h))
        else $error("exec without station match");
    mode_ch2_a: assert property (ctrl_h == $past(ctrl_h) |-> ch2_mode_o == mode_of(ctrl_h[7:4]))
        else $error("channel two mode wrong");
    mode_ch1_a: assert property (ctrl_h == $past(ctrl_h) |-> ch1_mode_o == mode_of(eff1))
        else $error("channel one mode wrong");
    loop_sel_a: assert property (ctrl_h == $past(ctrl_h) && !no_lb |-> loopback_o)
        else $error("loopback not shown");
    mem_sel_a: assert property (ctrl_h == $past(ctrl_h) && ctrl_h[7:4] == `DCLR_PROTO_MEMTEST |-> memtest_o)
        else $error("memtest not shown");
    idle_no_rx_a: assert property (!linked && no_lb && ctrl_h == $past(ctrl_h) |-> !ch1_rx_ready_o && !ch2_rx_ready_o)
        else $error("rx taken while unlinked");
    relay_fwd_a: assert property (np_link && ch1_rx_valid_i && ch1_rx_ready_o && !ch2_tx_valid_o
        |=> ch2_tx_valid_o && ch2_tx_data_o == $past(ch1_rx_data_i)) else $error("ch1 char not relayed");
    relay_back_a: assert property (np_link && ch2_rx_valid_i && ch2_rx_ready_o && !ch1_tx_valid_o
        |=> ch1_tx_valid_o && ch1_tx_data_o == $past(ch2_rx_data_i)) else $error("ch2 char not relayed");
    tx_hold_a: assert property (ch2_tx_valid_o && !ch2_tx_ready_i |=> ch2_tx_valid_o && $stable(ch2_tx_data_o))
        else $error("stalled char lost");
    bad_addr_a: assert property (psel_i && penable_i && bad_addr |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    rd_idle_a: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("read bus busy outside access");
    cover property (cmd_exec_o);
    cover property (linked && ch2_tx_valid_o && ch2_tx_ready_i);
    cover property (pslverr_o);
endmodule
bind dclr_link_relay dclr_link_props #(.HDR_DEPTH(HDR_DEPTH)) u_props (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ch1_rx_valid_i(ch1_rx_valid_i), .ch1_rx_ready_o(ch1_rx_ready_o),
    .ch1_rx_data_i(ch1_rx_data_i), .ch1_tx_valid_o(ch1_tx_valid_o), .ch1_tx_data_o(ch1_tx_data_o),
    .ch2_rx_valid_i(ch2_rx_valid_i), .ch2_rx_ready_o(ch2_rx_ready_o), .ch2_rx_data_i(ch2_rx_data_i),
    .ch2_tx_valid_o(ch2_tx_valid_o), .ch2_tx_ready_i(ch2_tx_ready_i), .ch2_tx_data_o(ch2_tx_data_o),
    .cmd_station_valid_i(cmd_station_valid_i), .cmd_station_i(cmd_station_i), .cmd_exec_o(cmd_exec_o),
    .ch1_mode_o(ch1_mode_o), .ch2_mode_o(ch2_mode_o), .loopback_o(loopback_o), .memtest_o(memtest_o));

// ===== dv/tb_dual_channel_serial_link_relay.sv
// Purpose: directed test of the link relay
// Assumes: APB master waits on pready
// Notes: far ends log relayed chars
`timescale 1ns/100ps
`include "dclr_consts.vh"
module tb_dual_channel_serial_link_relay;
    reg mclk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, cmd_station_valid_i = 1'b0;
    reg [11:0] paddr_i = 12'h000;
    reg [31:0] pwdata_i = 32'h0, rd;
    reg ch1_rx_valid_i = 1'b0, ch2_rx_valid_i = 1'b0, er;
    reg [7:0] ch1_rx_data_i = 8'h00, ch2_rx_data_i = 8'h00;
    reg [4:0] cmd_station_i = 5'h00;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, ch1_rx_ready_o, ch2_rx_ready_o, ch1_tx_valid_o, ch2_tx_valid_o;
    wire ch1_tx_ready_i, ch2_tx_ready_i, cmd_exec_o, loopback_o, memtest_o;
    wire [7:0] ch1_tx_data_o, ch2_tx_data_o;
    wire [1:0] ch1_mode_o, ch2_mode_o;
    reg [7:0] tx_b[0:31], ex_b[0:31];
    integer err_total = 0, n_tests = 0, c, i, hl;
    dclr_link_relay DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .ch1_rx_valid_i(ch1_rx_valid_i), .ch1_rx_ready_o(ch1_rx_ready_o),
        .ch1_rx_data_i(ch1_rx_data_i), .ch1_tx_valid_o(ch1_tx_valid_o), .ch1_tx_ready_i(ch1_tx_ready_i),
        .ch1_tx_data_o(ch1_tx_data_o), .ch2_rx_valid_i(ch2_rx_valid_i), .ch2_rx_ready_o(ch2_rx_ready_o),
        .ch2_rx_data_i(ch2_rx_data_i), .ch2_tx_valid_o(ch2_tx_valid_o), .ch2_tx_ready_i(ch2_tx_ready_i),
        .ch2_tx_data_o(ch2_tx_data_o), .cmd_station_valid_i(cmd_station_valid_i), .cmd_station_i(cmd_station_i),
        .cmd_exec_o(cmd_exec_o), .ch1_mode_o(ch1_mode_o), .ch2_mode_o(ch2_mode_o), .loopback_o(loopback_o),
        .memtest_o(memtest_o));
    dclr_far_end u_far1 (.mclk_i(mclk_i), .resetn_i(resetn_i), .stall_i(1'b0), .tx_valid_i(ch1_tx_valid_o),
        .tx_ready_o(ch1_tx_ready_i), .tx_data_i(ch1_tx_data_o));
    dclr_far_end u_far2 (.mclk_i(mclk_i), .resetn_i(resetn_i), .stall_i(1'b1), .tx_valid_i(ch2_tx_valid_o),
        .tx_ready_o(ch2_tx_ready_i), .tx_data_i(ch2_tx_data_o));
    always #5 mclk_i = ~mclk_i;
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk_i);
            psel_i <= 1'b1;
            pwrite_i <= w;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge mclk_i);
            penable_i <= 1'b1;
            do @(posedge mclk_i); while (pready_o !== 1'b1);
            rd = prdata_o;
            er = pslverr_o;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task send(input integer ch, input [7:0] d);
        begin
            if (ch == 1) begin
                ch1_rx_valid_i <= 1'b1;
                ch1_rx_data_i <= d;
            end else begin
                ch2_rx_valid_i <= 1'b1;
                ch2_rx_data_i <= d;
            end
            do @(posedge mclk_i); while ((ch == 1 ? ch1_rx_ready_o : ch2_rx_ready_o) !== 1'b1);
        end
    endtask
    task relay(input integer ch, input integer ns, input integer ne);
        integer k;
        begin
            for (k = 0; k < ns; k = k + 1)
                send(ch, tx_b[k]);
            ch1_rx_valid_i <= 1'b0;
            ch2_rx_valid_i <= 1'b0;
            ch1_rx_data_i <= ~ch1_rx_data_i;
            ch2_rx_data_i <= ~ch2_rx_data_i;
            while ((ch == 1 ? u_far2.got_q.size() : u_far1.got_q.size()) < ne) @(posedge mclk_i);
            for (k = 0; k < ne; k = k + 1)
                chk(ch == 1 ? u_far2.got_q[k] : u_far1.got_q[k], ex_b[k]);
            u_far1.got_q.delete();
            u_far2.got_q.delete();
        end
    endtask
    task final_report;
        begin
            if (err_total == 0 && n_tests > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #300000;
        err_total = err_total + 1;
        final_report;
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        apb(1'b0, `DCLR_OFF_CTRL, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, `DCLR_OFF_STATION, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h07c, 32'h0);
        chk(rd, 32'h30);
        apb(1'b0, 12'h00c, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        for (c = 0; c < 12; c = c + 1) begin
            if (c != 8) begin
                apb(1'b1, `DCLR_OFF_CTRL, 32'h100 | (c << 4));
                repeat (2) @(posedge mclk_i);
                chk(ch2_mode_o, c == 0 ? 0 : c < 5 ? 1 : c == 5 ? 2 : 3);
                chk(memtest_o, c == 10);
                chk(loopback_o, c == 11);
            end
        end
        // Linked nonprocedural pair, same four chars relayed in both directions
        apb(1'b1, `DCLR_OFF_CTRL, 32'h168);
        for (i = 0; i < 4; i = i + 1) begin
            tx_b[i] = 8'h41 + i;
            ex_b[i] = 8'h41 + i;
        end
        relay(1, 4, 4);
        relay(2, 4, 4);
        for (i = 0; i < 16; i = i + 1)
            apb(1'b1, `DCLR_OFF_HDR_BASE + 4 * i, 32'h50 + i);
        for (c = 1; c < 6; c = c + 1) begin
            apb(1'b1, `DCLR_OFF_CTRL, 32'h108 | (c << 4));
            hl = c == 1 ? 0 : c == 2 ? 15 : c == 5 ? 10 : 13;
            for (i = 0; i < hl; i = i + 1)
                ex_b[i] = 8'h50 + i;
            tx_b[0] = c == 5 ? `DCLR_CH_DLE : `DCLR_CH_STX;
            tx_b[1] = c == 5 ? `DCLR_CH_STX : 8'h41;
            tx_b[2] = 8'h03;
            for (i = 0; i < 3; i = i + 1)
                ex_b[hl + i] = tx_b[i];
            relay(1, 3, hl + 3);
            for (i = 0; i < hl; i = i + 1)
                tx_b[i] = 8'h60 + i;
            tx_b[hl] = c == 5 ? `DCLR_CH_DLE : `DCLR_CH_ACK;
            tx_b[hl + 1] = 8'h42;
            tx_b[hl + 2] = 8'h03;
            for (i = 0; i < 3; i = i + 1)
                ex_b[i] = tx_b[hl + i];
            relay(2, hl + 3, 3);
            chk(ch1_mode_o, c == 5 ? 2 : 1);
        end
        apb(1'b1, `DCLR_OFF_STATION, 32'h1f);
        apb(1'b0, `DCLR_OFF_STATION, 32'h0);
        chk(rd, 32'h1f);
        for (i = 31; i > 29; i = i - 1) begin
            cmd_station_i <= i[4:0];
            cmd_station_valid_i <= 1'b1;
            @(posedge mclk_i);
            cmd_station_valid_i <= 1'b0;
            #1;
            chk(cmd_exec_o, i == 31);
            @(posedge mclk_i);
        end
        apb(1'b0, `DCLR_OFF_STATUS, 32'h0);
        chk(rd, 32'h0001_0003);
        final_report;
    end
endmodule

// ===== logic/dclr_consts.vh
// Purpose: constants for the two-channel link relay
// Assumes: APB register map, byte-wide channel streams
// Notes: offsets are byte addresses
`ifndef DCLR_CONSTS_VH
`define DCLR_CONSTS_VH
`define DCLR_OFF_CTRL 12'h000
`define DCLR_OFF_STATION 12'h004
`define DCLR_OFF_STATUS 12'h008
`define DCLR_OFF_HDR_BASE 12'h040
`define DCLR_PROTO_TOOL 4'h0
`define DCLR_PROTO_FMT1 4'h1
`define DCLR_PROTO_FMT2 4'h2
`define DCLR_PROTO_FMT3 4'h3
`define DCLR_PROTO_FMT4 4'h4
`define DCLR_PROTO_FMT5 4'h5
`define DCLR_PROTO_NONPROC 4'h6
`define DCLR_PROTO_BIDIR 4'h7
`define DCLR_PROTO_LINKED 4'h8
`define DCLR_PROTO_PREDEF 4'h9
`define DCLR_PROTO_MEMTEST 4'ha
`define DCLR_PROTO_LOOPBACK 4'hb
`define DCLR_HDR_LEN_ASCII 5'd13
`define DCLR_HDR_LEN_FMT2 5'd15
`define DCLR_HDR_LEN_BIN 5'd10
`define DCLR_HDR_DEPTH 16
`define DCLR_STATION_MAX 5'd31
`define DCLR_CH_ENQ 8'h05
`define DCLR_CH_STX 8'h02
`define DCLR_CH_ACK 8'h06
`define DCLR_CH_NAK 8'h15
`define DCLR_CH_DLE 8'h10
`define DCLR_CH_LF 8'h0a
`define DCLR_CH_ETX 8'h03
`define DCLR_HDR_RESET 8'h30
`endif

// ===== logic/dclr_link_relay.v
// Purpose: two-channel protocol select, station number, linked relay
// Assumes: byte streams per channel from external UARTs, APB registers
// Notes: header table writable over APB, reset to a neutral pattern
// How it works
// (RQ1) Each channel takes a protocol code from a twelve-value set.
// (RQ2) Formats one to four are ASCII, format five binary.
// (RQ3) Linked code on channel one links both; channel two protocol governs.
// (RQ4) Loopback code checks each interface; memtest code runs a test.
// (RQ5) Station number 0..31 held for multidrop addressing.
// (RQ6) Software sets station zero for a one-to-one system.
// (RQ7) Linked: every character from one channel leaves the other.
// (RQ8) Software keeps character settings equal and picks allowed protocols.
// (RQ9) Nonprocedural linked traffic reaches all; equipment arbitrates.
// (RQ10) Command executes only when message station equals own.
// (RQ11) Host commands to others get a header, then forwarded.
// (RQ12) Responses from others lose the header toward the host.
// (RQ13) Addressed station answers with header on the command channel.
// (RQ14) Header is sent also with many hosts and stations.
// (RQ15) ASCII header 13 chars, 15 for format two, before control code.
// (RQ16) Binary header 10 bytes before DLE STX.
// (RQ17) Software avoids linking with predefined, bidirectional or modem.
// (RQ18) Header bytes come from a writable constant table.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "dclr_consts.vh"
module dclr_link_relay #(
    parameter HDR_DEPTH = `DCLR_HDR_DEPTH
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output reg pslverr_o,
    input wire ch1_rx_valid_i,
    output wire ch1_rx_ready_o,
    input wire [7:0] ch1_rx_data_i,
    output wire ch1_tx_valid_o,
    input wire ch1_tx_ready_i,
    output wire [7:0] ch1_tx_data_o,
    input wire ch2_rx_valid_i,
    output wire ch2_rx_ready_o,
    input wire [7:0] ch2_rx_data_i,
    output wire ch2_tx_valid_o,
    input wire ch2_tx_ready_i,
    output wire [7:0] ch2_tx_data_o,
    input wire cmd_station_valid_i,
    input wire [4:0] cmd_station_i,
    output reg cmd_exec_o,
    output reg [1:0] ch1_mode_o,
    output reg [1:0] ch2_mode_o,
    output reg loopback_o,
    output reg memtest_o
);
    reg [3:0] ch1_proto_reg;
    reg [3:0] ch2_proto_reg;
    reg host_on_ch1_reg;
    reg [4:0] station_reg;
    reg [HDR_DEPTH*8-1:0] hdr_tbl_reg;
    reg [15:0] exec_count_reg;
    reg [15:0] exec_count_next;
    wire wr_en;
    wire rd_en;
    wire linked;
    wire [3:0] eff_proto;
    wire is_cmd;
    wire cmd_binary;
    wire hdr_frame;
    wire [4:0] hdr_len;
    wire busy_12;
    wire busy_21;
    wire p12_rx_ready;
    wire p21_rx_ready;
    wire p12_tx_valid;
    wire p21_tx_valid;
    wire [7:0] p12_tx_data;
    wire [7:0] p21_tx_data;
    integer k;

    // Mode class of a protocol code: 0 tool, 1 ascii, 2 binary, 3 other
    function [1:0] proto_class;
        input [3:0] code;
        begin
            case (code)
                `DCLR_PROTO_TOOL: proto_class = 2'd0;
                `DCLR_PROTO_FMT1, `DCLR_PROTO_FMT2, `DCLR_PROTO_FMT3, `DCLR_PROTO_FMT4: proto_class = 2'd1;
                `DCLR_PROTO_FMT5: proto_class = 2'd2;
                default: proto_class = 2'd3;
            endcase
        end
    endfunction

    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;

    // (RQ3) Linked via channel one
    assign linked = (ch1_proto_reg == `DCLR_PROTO_LINKED);
    assign eff_proto = ch2_proto_reg;
    assign is_cmd = (proto_class(eff_proto) == 2'd1) || (proto_class(eff_proto) == 2'd2);
    assign cmd_binary = (proto_class(eff_proto) == 2'd2);
    // (RQ11) Header frames two to five
    assign hdr_frame = linked && is_cmd && (eff_proto != `DCLR_PROTO_FMT1);
    // (RQ15) ASCII and binary lengths
    assign hdr_len = cmd_binary ? `DCLR_HDR_LEN_BIN :
        ((eff_proto == `DCLR_PROTO_FMT2) ? `DCLR_HDR_LEN_FMT2 : `DCLR_HDR_LEN_ASCII);

    // Register writes
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            ch1_proto_reg <= `DCLR_PROTO_TOOL;
            ch2_proto_reg <= `DCLR_PROTO_TOOL;
            host_on_ch1_reg <= 1'b1;
            station_reg <= 5'd0;
            for (k = 0; k < HDR_DEPTH; k = k + 1) begin
                hdr_tbl_reg[k*8 +: 8] <= `DCLR_HDR_RESET;
            end
        end else if (wr_en) begin
            if (paddr_i == `DCLR_OFF_CTRL) begin
                // (RQ1) Protocol per channel
                ch1_proto_reg <= pwdata_i[3:0];
                ch2_proto_reg <= pwdata_i[7:4];
                host_on_ch1_reg <= pwdata_i[8];
            end else if (paddr_i == `DCLR_OFF_STATION) begin
                // (RQ5) Station range
                station_reg <= pwdata_i[4:0];
            end else begin
                // (RQ18) Header table writes
                for (k = 0; k < HDR_DEPTH; k = k + 1) begin
                    if (paddr_i == `DCLR_OFF_HDR_BASE + k * 4) begin
                        hdr_tbl_reg[k*8 +: 8] <= pwdata_i[7:0];
                    end
                end
            end
        end
    end

    // Read mux and unmapped error
    always @* begin
        prdata_o = 32'h0000_0000;
        pslverr_o = 1'b0;
        if (paddr_i == `DCLR_OFF_CTRL) begin
            prdata_o = {23'h0, host_on_ch1_reg, ch2_proto_reg, ch1_proto_reg};
        end else if (paddr_i == `DCLR_OFF_STATION) begin
            prdata_o = {27'h0, station_reg};
        end else if (paddr_i == `DCLR_OFF_STATUS) begin
            prdata_o = {exec_count_reg, 8'h0, 2'b00, busy_21, busy_12, memtest_o, loopback_o, cmd_binary, linked};
        end else if (paddr_i >= `DCLR_OFF_HDR_BASE && paddr_i < `DCLR_OFF_HDR_BASE + HDR_DEPTH * 4 &&
                     paddr_i[1:0] == 2'b00) begin
            prdata_o = {24'h0, hdr_tbl_reg[((paddr_i - `DCLR_OFF_HDR_BASE) >> 2)*8 +: 8]};
        end else if (psel_i && penable_i) begin
            pslverr_o = 1'b1;
        end
        if (!rd_en) begin
            prdata_o = 32'h0000_0000;
        end
    end

    // Status outputs and command match
    always @* begin
        exec_count_next = exec_count_reg;
        // (RQ10) Execute only own station
        if (cmd_station_valid_i && is_cmd && cmd_station_i == station_reg) begin
            exec_count_next = exec_count_reg + 16'd1;
        end
    end

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            cmd_exec_o <= 1'b0;
            exec_count_reg <= 16'd0;
            ch1_mode_o <= 2'd0;
            ch2_mode_o <= 2'd0;
            loopback_o <= 1'b0;
            memtest_o <= 1'b0;
        end else begin
            cmd_exec_o <= cmd_station_valid_i && is_cmd && (cmd_station_i == station_reg);
            exec_count_reg <= exec_count_next;
            // (RQ2) ASCII vs binary mode
            ch1_mode_o <= linked ? proto_class(eff_proto) : proto_class(ch1_proto_reg);
            ch2_mode_o <= proto_class(eff_proto);
            // (RQ4) Loopback and memtest
            loopback_o <= (ch1_proto_reg == `DCLR_PROTO_LOOPBACK) || (ch2_proto_reg == `DCLR_PROTO_LOOPBACK);
            memtest_o <= (ch1_proto_reg == `DCLR_PROTO_MEMTEST) || (ch2_proto_reg == `DCLR_PROTO_MEMTEST);
        end
    end

    // (RQ7) Channel one to two path
    // (RQ14) Header inserted regardless of station count
    dclr_relay_path #(
        .DEPTH(HDR_DEPTH)
    ) u_p12 (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .insert_i(hdr_frame && host_on_ch1_reg),
        .strip_i(hdr_frame && !host_on_ch1_reg),
        .binary_i(cmd_binary),
        .hdr_len_i(hdr_len),
        .hdr_tbl_i(hdr_tbl_reg),
        .rx_valid_i(ch1_rx_valid_i && (linked || loopback_o)),
        .rx_ready_o(p12_rx_ready),
        .rx_data_i(ch1_rx_data_i),
        .tx_valid_o(p12_tx_valid),
        .tx_ready_i(loopback_o ? ch1_tx_ready_i : ch2_tx_ready_i),
        .tx_data_o(p12_tx_data),
        .busy_o(busy_12)
    );

    // (RQ12) Channel two to one path strips when the host is on channel one
    // (RQ13) Inserts the command header only when the host is on channel two
    dclr_relay_path #(
        .DEPTH(HDR_DEPTH)
    ) u_p21 (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .insert_i(hdr_frame && !host_on_ch1_reg),
        .strip_i(hdr_frame && host_on_ch1_reg),
        .binary_i(cmd_binary),
        .hdr_len_i(hdr_len),
        .hdr_tbl_i(hdr_tbl_reg),
        .rx_valid_i(ch2_rx_valid_i && (linked || loopback_o)),
        .rx_ready_o(p21_rx_ready),
        .rx_data_i(ch2_rx_data_i),
        .tx_valid_o(p21_tx_valid),
        .tx_ready_i(loopback_o ? ch2_tx_ready_i : ch1_tx_ready_i),
        .tx_data_o(p21_tx_data),
        .busy_o(busy_21)
    );

    assign ch1_rx_ready_o = (linked || loopback_o) && p12_rx_ready;
    assign ch2_rx_ready_o = (linked || loopback_o) && p21_rx_ready;
    // Loopback returns each channel's data on itself
    assign ch1_tx_valid_o = loopback_o ? p12_tx_valid : (linked && p21_tx_valid);
    assign ch1_tx_data_o = loopback_o ? p12_tx_data : p21_tx_data;
    assign ch2_tx_valid_o = loopback_o ? p21_tx_valid : (linked && p12_tx_valid);
    assign ch2_tx_data_o = loopback_o ? p21_tx_data : p12_tx_data;
endmodule

// ===== logic/dclr_relay_path.v
// Purpose: one relay direction, optional header insert or strip
// Assumes: header table supplied by the owner as a flat vector
// Notes: inserts header ahead of a start code, strips a leading header
`timescale 1ns/100ps
`include "dclr_consts.vh"
module dclr_relay_path #(
    parameter DEPTH = 16
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire insert_i,
    input wire strip_i,
    input wire binary_i,
    input wire [4:0] hdr_len_i,
    input wire [DEPTH*8-1:0] hdr_tbl_i,
    input wire rx_valid_i,
    output wire rx_ready_o,
    input wire [7:0] rx_data_i,
    output wire tx_valid_o,
    input wire tx_ready_i,
    output wire [7:0] tx_data_o,
    output wire busy_o
);
    reg [4:0] idx_reg;
    reg hdr_active_reg;
    reg strip_active_reg;
    reg in_msg_reg;
    reg prev_dle_reg;
    wire is_start;
    wire sv_ready;
    reg sv_valid;
    reg [7:0] sv_data;
    reg rx_take;
    wire hdr_go;
    wire strip_go;

    // Start code of a fresh message
    assign is_start = binary_i ? (prev_dle_reg && rx_data_i == `DCLR_CH_STX) :
        (rx_data_i == `DCLR_CH_ENQ || rx_data_i == `DCLR_CH_STX ||
         rx_data_i == `DCLR_CH_ACK || rx_data_i == `DCLR_CH_NAK);
    // (RQ16) Header before ASCII code or DLE STX
    assign hdr_go = rx_valid_i && !in_msg_reg && insert_i && (binary_i ? rx_data_i == `DCLR_CH_DLE : is_start);
    assign strip_go = rx_valid_i && !in_msg_reg && strip_i;

    always @* begin
        sv_valid = 1'b0;
        sv_data = rx_data_i;
        rx_take = 1'b0;
        if (hdr_active_reg) begin
            sv_valid = 1'b1;
            sv_data = hdr_tbl_i[idx_reg*8 +: 8];
        end else if (strip_active_reg || strip_go) begin
            rx_take = rx_valid_i;
        end else if (rx_valid_i && !hdr_go) begin
            sv_valid = 1'b1;
            rx_take = sv_ready;
        end
    end

    assign rx_ready_o = !hdr_active_reg && !hdr_go && (strip_active_reg || strip_go || sv_ready);
    assign busy_o = hdr_active_reg || strip_active_reg;

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            idx_reg <= 5'd0;
            hdr_active_reg <= 1'b0;
            strip_active_reg <= 1'b0;
            in_msg_reg <= 1'b0;
            prev_dle_reg <= 1'b0;
        end else if (hdr_active_reg) begin
            if (sv_ready) begin
                if (idx_reg == hdr_len_i - 5'd1) begin
                    hdr_active_reg <= 1'b0;
                    idx_reg <= 5'd0;
                end else begin
                    idx_reg <= idx_reg + 5'd1;
                end
            end
        end else if (hdr_go) begin
            // Start code waits behind the header
            hdr_active_reg <= 1'b1;
            idx_reg <= 5'd0;
            in_msg_reg <= 1'b1;
        end else if (strip_go) begin
            strip_active_reg <= 1'b1;
            idx_reg <= 5'd1;
            in_msg_reg <= 1'b1;
        end else if (strip_active_reg) begin
            if (rx_valid_i) begin
                if (idx_reg == hdr_len_i - 5'd1) begin
                    strip_active_reg <= 1'b0;
                    idx_reg <= 5'd0;
                end else begin
                    idx_reg <= idx_reg + 5'd1;
                end
            end
        end else if (rx_take) begin
            prev_dle_reg <= (rx_data_i == `DCLR_CH_DLE);
            // Line feed or ETX ends the message
            if (rx_data_i == `DCLR_CH_LF || rx_data_i == `DCLR_CH_ETX) begin
                in_msg_reg <= 1'b0;
            end
        end
    end

    dclr_skid #(
        .WIDTH(8)
    ) u_buf (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .in_valid_i(sv_valid),
        .in_ready_o(sv_ready),
        .in_data_i(sv_data),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );
endmodule

// ===== logic/dclr_skid.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: no word lost on stall
`timescale 1ns/100ps
module dclr_skid #(
    parameter WIDTH = 8
) (
    input wire mclk_i,
    input wire resetn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg rd_ptr_reg;
    reg wr_ptr_reg;
    reg [1:0] count_reg;
    wire push;
    wire pop;

    assign in_ready_o = (count_reg != 2'd2);
    assign out_valid_o = (count_reg != 2'd0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge mclk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end
endmodule
